// File: src/accumulator_alu_core.sv
// eight-bit alu datapath with working register and two-stage pipeline
`timescale 1ns/1ps
`include "alu_core_defines.svh"
module accumulator_alu_core (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // program bus
  output logic [`PC_W-1:0] pc_addr,
  input wire logic [`INSTR_W-1:0] instr_data,
  input wire logic page_sel,
  // data register file bus
  output logic [`FADDR_W-1:0] rf_addr,
  output logic rf_rd_en,
  input wire logic [`DATA_W-1:0] rf_rd_data,
  output logic rf_wr_en,
  output logic [`DATA_W-1:0] rf_wr_data,
  // core state
  output logic [`DATA_W-1:0] work_reg,
  output logic carry_flag,
  output logic nibble_carry_flag,
  output logic zero_flag,
  output alu_core_pkg::phase_t phase
);
  import alu_core_pkg::*;

  phase_t q_reg;
  logic [`PC_W-1:0] pc_reg;
  logic [`INSTR_W-1:0] ir_reg;
  logic flush_reg;
  logic [`DATA_W-1:0] w_reg;
  logic [`DATA_W-1:0] opnd_reg;
  logic [`DATA_W-1:0] result_reg;
  logic res_c_reg;
  logic res_dc_reg;
  logic c_reg;
  logic dc_reg;
  logic z_reg;

  // instruction field split
  wire [5:0] op6 = ir_reg[`INSTR_W-1:`OP6_LSB];
  wire [3:0] op4 = ir_reg[`INSTR_W-1:`OP4_LSB];
  wire [2:0] op3 = ir_reg[`INSTR_W-1:`OP3_LSB];
  wire dest_f = ir_reg[`D_BIT];
  wire [2:0] bsel = ir_reg[`BSEL_MSB:`BSEL_LSB];
  wire [`DATA_W-1:0] literal = ir_reg[`DATA_W-1:0];
  wire [`FADDR_W-1:0] faddr = ir_reg[`FADDR_W-1:0];
  wire exec = !flush_reg;

  // opcode decode
  wire is_lit = (op4 == `OPC_MOVLW) || (op4 == `OPC_IORLW) ||
                (op4 == `OPC_ANDLW) || (op4 == `OPC_XORLW);
  wire is_bit = (op4 == `OPC_BCF) || (op4 == `OPC_BSF) ||
                (op4 == `OPC_BTFSC) || (op4 == `OPC_BTFSS);
  wire is_dop = (op6 >= `OPC_SUBWF) && (op6 <= `OPC_INCFSZ);
  wire is_movwf = (op6 == `OPC_GRP0) && dest_f;
  wire is_clr = (op6 == `OPC_CLR);
  wire is_goto = (op3 == `OPC_GOTO);
  alu_op_t alu_op;
  assign alu_op =
    is_movwf ? OP_MOVW :
    is_clr ? OP_ZERO :
    (op6 == `OPC_SUBWF) ? OP_SUB :
    (op6 == `OPC_DECF) ? OP_DEC :
    (op6 == `OPC_IORWF || op4 == `OPC_IORLW) ? OP_IOR :
    (op6 == `OPC_ANDWF || op4 == `OPC_ANDLW) ? OP_AND :
    (op6 == `OPC_XORWF || op4 == `OPC_XORLW) ? OP_XOR :
    (op6 == `OPC_ADDWF) ? OP_ADD :
    (op6 == `OPC_MOVF) ? OP_MOVF :
    (op6 == `OPC_COMF) ? OP_COM :
    (op6 == `OPC_INCF) ? OP_INC :
    (op6 == `OPC_DECFSZ) ? OP_DECSK :
    (op6 == `OPC_RRF) ? OP_RR :
    (op6 == `OPC_RLF) ? OP_RL :
    (op6 == `OPC_SWAPF) ? OP_SWAP :
    (op6 == `OPC_INCFSZ) ? OP_INCSK :
    (op4 == `OPC_BCF) ? OP_BCLR :
    (op4 == `OPC_BSF) ? OP_BSET :
    (op4 == `OPC_BTFSC) ? OP_BTSTC :
    (op4 == `OPC_BTFSS) ? OP_BTSTS :
    (op4 == `OPC_MOVLW) ? OP_LOADK : OP_NONE;

  // destination and flag selection
  wire writes_w = is_lit || (is_dop && !dest_f) || (is_clr && !dest_f);
  wire writes_f = (is_dop && dest_f) || is_movwf || (is_clr && dest_f) ||
                  alu_op == OP_BCLR || alu_op == OP_BSET;
  wire aff_c = alu_op == OP_SUB || alu_op == OP_ADD ||
               alu_op == OP_RR || alu_op == OP_RL;
  wire aff_dc = alu_op == OP_SUB || alu_op == OP_ADD;
  wire aff_z = alu_op == OP_ZERO || alu_op == OP_SUB ||
               alu_op == OP_DEC || alu_op == OP_IOR ||
               alu_op == OP_AND || alu_op == OP_XOR ||
               alu_op == OP_ADD || alu_op == OP_MOVF ||
               alu_op == OP_COM || alu_op == OP_INC;
  wire wr_pcl = writes_f && faddr == `ADDR_PCL;
  wire wr_status = writes_f && faddr == `ADDR_STATUS;

  // second source: literal or any file register, pc and flags mapped in
  wire [`DATA_W-1:0] status_view = {rf_rd_data[`DATA_W-1:`BIT_Z+1],
                                    z_reg, dc_reg, c_reg};
  wire [`DATA_W-1:0] file_view = (faddr == `ADDR_PCL) ? pc_reg[`DATA_W-1:0] :
                                 (faddr == `ADDR_STATUS) ? status_view :
                                 rf_rd_data;
  wire [`DATA_W-1:0] src_b = is_lit ? literal : file_view;

  // adder shared by add and subtract; subtract is f + ~w + 1
  wire is_sub = alu_op == OP_SUB;
  wire [`DATA_W-1:0] add_w = is_sub ? ~w_reg : w_reg;
  wire [`DATA_W:0] sum9 = {1'b0, opnd_reg} + {1'b0, add_w} +
                          {{`DATA_W{1'b0}}, is_sub};
  wire [`NIB_W:0] nib5 = {1'b0, opnd_reg[`NIB_MSB:0]} +
                         {1'b0, add_w[`NIB_MSB:0]} +
                         {{`NIB_W{1'b0}}, is_sub};
  wire [`DATA_W-1:0] bit_mask = `DATA_W'(1) << bsel;
  wire bit_val = |(opnd_reg & bit_mask);
  wire [`DATA_W-1:0] inc_v = opnd_reg + `DATA_W'(1);
  wire [`DATA_W-1:0] dec_v = opnd_reg - `DATA_W'(1);

  // alu result and carries for the current instruction
  logic [`DATA_W-1:0] alu_res;
  logic alu_c;
  logic alu_dc;
  always_comb begin
    alu_c = c_reg;
    alu_dc = dc_reg;
    case (alu_op)
      OP_MOVW: alu_res = w_reg;
      OP_ZERO: alu_res = '0;
      OP_SUB, OP_ADD: begin
        alu_res = sum9[`DATA_W-1:0];
        alu_c = sum9[`DATA_W];
        alu_dc = nib5[`NIB_W];
      end
      OP_DEC, OP_DECSK: alu_res = dec_v;
      OP_IOR: alu_res = w_reg | opnd_reg;
      OP_AND: alu_res = w_reg & opnd_reg;
      OP_XOR: alu_res = w_reg ^ opnd_reg;
      OP_COM: alu_res = ~opnd_reg;
      OP_INC, OP_INCSK: alu_res = inc_v;
      OP_RR: begin
        alu_res = {c_reg, opnd_reg[`DATA_W-1:1]};
        alu_c = opnd_reg[0];
      end
      OP_RL: begin
        alu_res = {opnd_reg[`DATA_W-2:0], c_reg};
        alu_c = opnd_reg[`DATA_W-1];
      end
      OP_SWAP: alu_res = {opnd_reg[`NIB_MSB:0],
                          opnd_reg[`DATA_W-1:`NIB_W]};
      OP_BCLR: alu_res = opnd_reg & ~bit_mask;
      OP_BSET: alu_res = opnd_reg | bit_mask;
      default: alu_res = opnd_reg;
    endcase
  end

  // skip and branch decisions, taken at the fourth phase
  wire res_zero = result_reg == '0;
  wire skip_hit = ((alu_op == OP_DECSK || alu_op == OP_INCSK) && res_zero) ||
                  (alu_op == OP_BTSTC && !bit_val) ||
                  (alu_op == OP_BTSTS && bit_val);
  wire take_branch = exec && (is_goto || wr_pcl || skip_hit);
  wire [`PC_W-1:0] goto_pc = {page_sel, ir_reg[`K9_MSB:0]};
  wire [`PC_W-1:0] pcl_pc = {pc_reg[`PC_W-1:`DATA_W], result_reg};
  wire [`PC_W-1:0] pc_next = !take_branch ? pc_reg + `PC_W'(1) :
                             is_goto ? goto_pc :
                             wr_pcl ? pcl_pc :
                             pc_reg + `PC_W'(1);

  // status written by data, with alu flags guarding their own bits
  wire [`DATA_W-1:0] status_wr = {result_reg[`DATA_W-1:`BIT_Z+1],
    aff_z ? res_zero : result_reg[`BIT_Z],
    aff_dc ? res_dc_reg : result_reg[`BIT_DC],
    aff_c ? res_c_reg : result_reg[`BIT_C]};

  // file image of status: flag bits the op affects come from the flag logic, the rest from data
  wire [`DATA_W-1:0] status_cap = {alu_res[`DATA_W-1:`BIT_Z+1],
    aff_z ? (alu_res == '0) : alu_res[`BIT_Z],
    aff_dc ? alu_dc : alu_res[`BIT_DC],
    aff_c ? alu_c : alu_res[`BIT_C]};
  wire [`DATA_W-1:0] wr_data_next = wr_status ? status_cap : alu_res;
  logic [`DATA_W-1:0] wr_data_reg;

  // bus strobes per phase
  assign rf_addr = faddr;
  assign rf_rd_en = q_reg == PH_Q2 && exec && !is_lit;
  assign rf_wr_en = q_reg == PH_Q4 && exec && writes_f;
  assign rf_wr_data = wr_data_reg; // registered write data
  assign pc_addr = pc_reg;
  assign work_reg = w_reg;
  assign carry_flag = c_reg;
  assign nibble_carry_flag = dc_reg;
  assign zero_flag = z_reg;
  assign phase = q_reg;

  // four-phase sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_reg <= PH_Q1;
    end else begin
      case (q_reg)
        PH_Q1: q_reg <= PH_Q2;
        PH_Q2: q_reg <= PH_Q3;
        PH_Q3: q_reg <= PH_Q4;
        default: q_reg <= PH_Q1;
      endcase
    end
  end

  // operand capture in q2, result in q3
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      opnd_reg <= '0;
      result_reg <= '0;
      wr_data_reg <= '0;
      res_c_reg <= 1'b0;
      res_dc_reg <= 1'b0;
    end else if (q_reg == PH_Q2) begin
      opnd_reg <= src_b;
    end else if (q_reg == PH_Q3) begin
      result_reg <= alu_res;
      res_c_reg <= alu_c;
      res_dc_reg <= alu_dc;
      wr_data_reg <= wr_data_next;
    end
  end

  // fetch and commit at the end of each instruction cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_reg <= `RESET_VECTOR;
      ir_reg <= `NOP_WORD;
      flush_reg <= 1'b1;
    end else if (q_reg == PH_Q4) begin
      pc_reg <= pc_next;
      ir_reg <= instr_data;
      flush_reg <= take_branch;
    end
  end

  // working register and flags commit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_reg <= '0;
      c_reg <= 1'b0;
      dc_reg <= 1'b0;
      z_reg <= 1'b0;
    end else if (q_reg == PH_Q4 && exec) begin
      if (writes_w) w_reg <= result_reg;
      if (aff_c) c_reg <= res_c_reg;
      else if (wr_status) c_reg <= status_wr[`BIT_C];
      if (aff_dc) dc_reg <= res_dc_reg;
      else if (wr_status) dc_reg <= status_wr[`BIT_DC];
      if (aff_z) z_reg <= res_zero;
      else if (wr_status) z_reg <= status_wr[`BIT_Z];
    end
  end

  wire [`DATA_W:0] add_ref = {1'b0, w_reg} + {1'b0, opnd_reg};

  phase_walk_a: assert property (@(posedge clk) disable iff (!resetn)
    q_reg == PH_Q1 |=> q_reg == PH_Q2 ##1 q_reg == PH_Q3
      ##1 q_reg == PH_Q4 ##1 q_reg == PH_Q1)
    else $error("phase sequence broken");
  read_phase_a: assert property (@(posedge clk) disable iff (!resetn)
    rf_rd_en |-> q_reg == PH_Q2 ##1 opnd_reg == $past(src_b))
    else $error("operand not read in second phase");
  write_phase_a: assert property (@(posedge clk)
    disable iff (!resetn)
    rf_wr_en |-> q_reg == PH_Q4 && $past(q_reg) == PH_Q3)
    else $error("file write outside fourth phase");
  zero_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    q_reg == PH_Q4 && exec && aff_z |=> zero_flag == ($past(result_reg) == 0))
    else $error("zero flag wrong");
  add_carry_a: assert property (@(posedge clk) disable iff (!resetn)
    q_reg == PH_Q4 && exec && alu_op == OP_ADD
      |=> {carry_flag, $past(result_reg)} == $past(add_ref, 2))
    else $error("add result or carry wrong");
  sub_borrow_a: assert property (@(posedge clk) disable iff (!resetn)
    q_reg == PH_Q4 && exec && is_sub
      |=> carry_flag == ($past(opnd_reg) >= $past(w_reg)) &&
          nibble_carry_flag == ($past(opnd_reg[`NIB_MSB:0]) >=
                                $past(w_reg[`NIB_MSB:0])))
    else $error("subtract borrow flags wrong");
  branch_flush_a: assert property (@(posedge clk)
    disable iff (!resetn)
    q_reg == PH_Q4 && take_branch |=> flush_reg [*4] ##1 !flush_reg)
    else $error("branch did not flush exactly one word");
  pc_step_a: assert property (@(posedge clk) disable iff (!resetn)
    q_reg == PH_Q4 && !take_branch |=> pc_addr == $past(pc_addr) + 10'h001)
    else $error("pc did not advance by one");
  status_guard_a: assert property (@(posedge clk)
    disable iff (!resetn)
    q_reg == PH_Q4 && exec && wr_status && aff_c
      |=> carry_flag == $past(res_c_reg))
    else $error("status data overrode carry");
  status_image_a: assert property (@(posedge clk)
    disable iff (!resetn)
    rf_wr_en && wr_status && aff_z |-> rf_wr_data[`BIT_Z] == res_zero)
    else $error("status image lost the zero flag");
  w_private_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(w_reg) |-> $past(q_reg == PH_Q4 && exec && writes_w))
    else $error("working register changed without a w destination");
endmodule : accumulator_alu_core

// File: src/alu_core_defines.svh
// constants for the accumulator alu core
// What this block does
// - eight-bit alu adds, subtracts, shifts and does bitwise logic
// - arithmetic results are two's complement
// - two-operand ops use working register plus file register or literal
// - single-operand ops use working register or a file register
// - working register is eight bits and has no file address
// - carry, nibble carry and zero flags update per instruction
// - subtraction carry is inverted byte borrow, nibble carry is inverted low-nibble borrow
// - twelve-bit instruction fetched whole on its own program bus
// - fetch overlaps execute; non-branch instructions take one cycle
// - program space is 1K words of twelve bits
// - pc low byte and status are reached by ordinary file accesses
// - every operation works on every register, by direct address only
// - alu second source may be any file register
// - instruction cycle spans four non-overlapping clock phases
// - operand read in second phase, result written in fourth
// - branches take two cycles; the prefetched word is discarded
// - flag-affecting write to status keeps alu flags, not data bits
`ifndef ALU_CORE_DEFINES_SVH
`define ALU_CORE_DEFINES_SVH
`define DATA_W 8
`define INSTR_W 12
`define PC_W 10
`define FADDR_W 5
`define RESET_VECTOR 10'h3FF
`define NOP_WORD 12'h000
`define ADDR_PCL 5'h02
`define ADDR_STATUS 5'h03
`define BIT_C 0
`define BIT_DC 1
`define BIT_Z 2
`define NIB_MSB 3
`define NIB_W 4
`define D_BIT 5
`define BSEL_MSB 7
`define BSEL_LSB 5
`define K9_MSB 8
`define OP6_LSB 6
`define OP4_LSB 8
`define OP3_LSB 9
`define OPC_GRP0 6'h00
`define OPC_CLR 6'h01
`define OPC_SUBWF 6'h02
`define OPC_DECF 6'h03
`define OPC_IORWF 6'h04
`define OPC_ANDWF 6'h05
`define OPC_XORWF 6'h06
`define OPC_ADDWF 6'h07
`define OPC_MOVF 6'h08
`define OPC_COMF 6'h09
`define OPC_INCF 6'h0A
`define OPC_DECFSZ 6'h0B
`define OPC_RRF 6'h0C
`define OPC_RLF 6'h0D
`define OPC_SWAPF 6'h0E
`define OPC_INCFSZ 6'h0F
`define OPC_BCF 4'h4
`define OPC_BSF 4'h5
`define OPC_BTFSC 4'h6
`define OPC_BTFSS 4'h7
`define OPC_MOVLW 4'hC
`define OPC_IORLW 4'hD
`define OPC_ANDLW 4'hE
`define OPC_XORLW 4'hF
`define OPC_GOTO 3'h5
`define REF_CYCLE_NS 200
`define REF_CLK_MHZ 20
`define CLK_MHZ 40
`define PHASES (`REF_CYCLE_NS * `REF_CLK_MHZ / 1000)
`endif

// File: src/alu_core_pkg.sv
// types for the accumulator alu core
package alu_core_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_MOVW, OP_ZERO, OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR,
    OP_ADD, OP_MOVF, OP_COM, OP_INC, OP_DECSK, OP_RR, OP_RL, OP_SWAP,
    OP_INCSK, OP_BCLR, OP_BSET, OP_BTSTC, OP_BTSTS, OP_LOADK
  } alu_op_t;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
endpackage : alu_core_pkg

// File: tb/accumulator_alu_core_tb_top.sv
// self-checking bench for the accumulator alu core
`timescale 1ns/1ps
`include "alu_core_defines.svh"
module accumulator_alu_core_tb_top;
  import alu_core_pkg::*;
  logic clk;
  logic resetn;
  logic page_sel;
  logic [`PC_W-1:0] pc_addr;
  logic [`INSTR_W-1:0] instr_data;
  logic [`FADDR_W-1:0] rf_addr;
  logic rf_rd_en;
  logic [`DATA_W-1:0] rf_rd_data;
  logic rf_wr_en;
  logic [`DATA_W-1:0] rf_wr_data;
  logic [`DATA_W-1:0] work_reg;
  logic carry_flag;
  logic nibble_carry_flag;
  logic zero_flag;
  phase_t phase;
  int failures;
  int checks_done;
  // program: literal, add, subtract, logic, shifts, goto, status write
  logic [11:0] prog_words [0:15] = '{12'hC0F, 12'h1D0, 12'hC05, 12'h091,
    12'hC03, 12'h0B1, 12'hFFF, 12'h312, 12'hE0F, 12'hD81, 12'h353,
    12'hA0E, 12'hCAA, 12'hCBB, 12'hC55, 12'h1E3};
  // upper page: file moves, clear, complement, skips over discarded words
  logic [11:0] page_words [0:11] = '{12'hC7E, 12'h034, 12'h394, 12'h075,
    12'h274, 12'h275, 12'h3F5, 12'hC11,
    12'h7F4, 12'hC22, 12'h414, 12'h214};
  // per step: pc reached, w, {zero, nibble carry, carry}, clocks since last
  logic [9:0] st_pc [0:24] = '{10'h002, 10'h003, 10'h004, 10'h005,
    10'h006, 10'h007, 10'h008, 10'h009, 10'h00A, 10'h00B, 10'h00C,
    10'h00F, 10'h010, 10'h011, 10'h201, 10'h202, 10'h203, 10'h204,
    10'h205, 10'h206, 10'h207, 10'h208, 10'h20A, 10'h20C, 10'h20D};
  logic [7:0] st_w [0:24] = '{8'h0F, 8'h10, 8'h05, 8'hFE, 8'h03, 8'h03,
    8'hFC, 8'hC0, 8'h00, 8'h81, 8'h41, 8'h41, 8'h55, 8'h55,
    8'h55, 8'h7E, 8'h7E, 8'hE7, 8'hE7, 8'hE7, 8'hE7, 8'hE7,
    8'hE7, 8'hE7, 8'h80};
  logic [2:0] st_f [0:24] = '{3'h0, 3'h2, 3'h2, 3'h0, 3'h0, 3'h7, 3'h3,
    3'h3, 3'h7, 3'h3, 3'h2, 3'h2, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [3:0] st_gap [0:24] = '{4'h0, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4,
    4'h4, 4'h4, 4'h4, 4'h4, 4'h8, 4'h4, 4'h4, 4'h8, 4'h4, 4'h4, 4'h4,
    4'h4, 4'h4, 4'h4, 4'h4, 4'h8, 4'h8, 4'h4};

  accumulator_alu_core i_accumulator_alu_core (
    .clk(clk), .resetn(resetn), .pc_addr(pc_addr),
    .instr_data(instr_data), .page_sel(page_sel), .rf_addr(rf_addr),
    .rf_rd_en(rf_rd_en), .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en),
    .rf_wr_data(rf_wr_data), .work_reg(work_reg),
    .carry_flag(carry_flag), .nibble_carry_flag(nibble_carry_flag),
    .zero_flag(zero_flag), .phase(phase)
  );

  program_data_model i_program_data_model (
    .clk(clk), .pc_addr(pc_addr), .instr_data(instr_data),
    .rf_addr(rf_addr), .rf_rd_en(rf_rd_en), .rf_rd_data(rf_rd_data),
    .rf_wr_en(rf_wr_en), .rf_wr_data(rf_wr_data)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare one value and count it
  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // print counts and verdict, then stop
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // wait for each step's pc at phase one and judge w, flags and spacing
  task automatic follow_steps(input int lo, input int hi);
    int n;
    for (int i = lo; i <= hi; i++) begin
      n = 0;
      while (!(pc_addr === st_pc[i] && phase === PH_Q1) && n < 100) begin
        @(negedge clk);
        n++;
      end
      check("pc", pc_addr, st_pc[i]);
      check("w", work_reg, st_w[i]);
      check("flags", {zero_flag, nibble_carry_flag, carry_flag},
            st_f[i]);
      if (st_gap[i] != 4'h0) check("gap", n[11:0], st_gap[i]);
    end
  endtask : follow_steps

  // reset values, then the four phases and the fetch wrap from 3FF
  task automatic run_reset();
    repeat (8) @(negedge clk);
    check("pc", pc_addr, 12'h3FF);
    check("w", work_reg, 12'h000);
    check("phase", phase, 12'h000);
    resetn = 1'b1;
    for (int k = 1; k <= 8; k++) begin
      @(negedge clk);
      check("phase", phase, k % 4);
      if (k == 4) check("pc", pc_addr, 12'h000);
    end
    $display("test reset done");
  endtask : run_reset

  // add with nibble carry, subtract with both borrows, zero result
  task automatic run_arith();
    follow_steps(0, 5);
    $display("test arith done");
  endtask : run_arith

  // literal logic ops and both rotates through carry
  task automatic run_logic();
    follow_steps(6, 10);
    $display("test logic done");
  endtask : run_logic

  // goto skips two words in two cycles, then status as a destination
  task automatic run_branch();
    follow_steps(11, 13);
    $display("test branch done");
  endtask : run_branch

  // file contents left by the writes in the fourth phase
  task automatic run_files();
    check("f11", i_program_data_model.regs[5'h11], 12'h000);
    check("f12", i_program_data_model.regs[5'h12], 12'h081);
    check("f03", i_program_data_model.regs[5'h03], 12'h050);
    $display("test files done");
  endtask : run_files

  // goto with the page bit high, then skips and file-only operations
  task automatic run_page();
    page_sel = 1'b1;
    follow_steps(14, 24);
    check("f14", i_program_data_model.regs[5'h14], 12'h080);
    check("f15", i_program_data_model.regs[5'h15], 12'h000);
    $display("test page done");
  endtask : run_page

  // main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    resetn = 1'b0;
    page_sel = 1'b0;
    for (int i = 0; i < 1024; i++) begin
      i_program_data_model.prog[i] = (i < 16) ? prog_words[i] : 12'h000;
    end
    i_program_data_model.prog[10'h010] = 12'hA00;
    for (int i = 0; i < 12; i++) begin
      i_program_data_model.prog[10'h200 + i] = page_words[i];
    end
    for (int i = 0; i < 32; i++) begin
      i_program_data_model.regs[i] = 8'h00;
    end
    i_program_data_model.regs[5'h10] = 8'h01;
    i_program_data_model.regs[5'h11] = 8'h03;
    i_program_data_model.regs[5'h12] = 8'h81;
    i_program_data_model.regs[5'h13] = 8'h20;
    run_reset();
    run_arith();
    run_logic();
    run_branch();
    run_files();
    run_page();
    test_done();
  end

  // watchdog well beyond the roughly 130 clocks the tests need
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : accumulator_alu_core_tb_top

// File: tb/program_data_model.sv
// behavioural program memory and data register file for the alu core
`timescale 1ns/1ps
`include "alu_core_defines.svh"
module program_data_model (
  // clock
  input wire logic clk,
  // program bus
  input wire logic [`PC_W-1:0] pc_addr,
  output logic [`INSTR_W-1:0] instr_data,
  // data register file bus
  input wire logic [`FADDR_W-1:0] rf_addr,
  input wire logic rf_rd_en,
  output logic [`DATA_W-1:0] rf_rd_data,
  input wire logic rf_wr_en,
  input wire logic [`DATA_W-1:0] rf_wr_data
);
  logic [`INSTR_W-1:0] prog [0:1023]; // all 1K words held here
  logic [`DATA_W-1:0] regs [0:31];
  // whole twelve-bit word for the address on the program bus
  assign instr_data = prog[pc_addr];
  // outside a read strobe show inverted data so stale values never match
  assign rf_rd_data = rf_rd_en ? regs[rf_addr] : ~regs[rf_addr];
  // destination write lands at the edge ending the write strobe
  always @(posedge clk) begin
    if (rf_wr_en) begin
      regs[rf_addr] <= rf_wr_data;
    end
  end
endmodule : program_data_model
